// *** design/pfc_regs.vh ***
`ifndef PFC_REGS_VH
`define PFC_REGS_VH
// Behaviour
// - the second cycle after the read bit is set does the array access
// - fetched word lands in the word pair the cycle after the access
// - word pair holds until another read completes or software writes it
// - erase, latch load and commits need a complete unbroken unlock
// - setting the write bit forces two no-operation cycles on the core
// - row erase or program stalls the core for the timed operation
// - a latch load only forces the two no-ops, then runs on unstalled
// - erase acts on a whole row picked by any address inside it
// - an erase takes two preparation cycles filled by no-operations
// - during the stall only the core halts, clocks and peripherals run
// - after an erase the core resumes at the third instruction onward
// - read and write bits are set by software, cleared by hardware
// - write or erase only with modify enable set; clear after reset
// - key register is write-only and reads back as zero
// - a reset that cuts a write sets the modify error flag

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PFC_ADDR_LOW_OFS  12'h000
`define PFC_ADDR_HIGH_OFS 12'h004
`define PFC_WORD_LOW_OFS  12'h008
`define PFC_WORD_HIGH_OFS 12'h00c
`define PFC_CONTROL_OFS   12'h010
`define PFC_KEY_OFS       12'h014

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define PFC_CTL_RD    0
`define PFC_CTL_WR    1
`define PFC_CTL_MODIFY_ENABLE       2
`define PFC_CTL_MODIFY_ERROR_FLAG   3
`define PFC_CTL_LOAD_ONLY           4
`define PFC_CTL_ERASE_SEL           5
`define PFC_CTL_CONFIG_SPACE_SELECT 6

// ----------------------------------------------------------------------
// reset values, keys, timing
// ----------------------------------------------------------------------
`define PFC_BYTE_RST   8'h00
`define PFC_KEY_FIRST  8'h55
`define PFC_KEY_SECOND 8'haa
`define PFC_OP_TIME_US 2000
`define PFC_CLK_MHZ    200
`define PFC_OP_CYCLES  (`PFC_OP_TIME_US * `PFC_CLK_MHZ)

`endif

// *** design/pfc_timer.v ***
`timescale 1ns/1ps
`include "pfc_regs.vh"

module pfc_timer #(
  parameter CYCLES = `PFC_OP_CYCLES,
  parameter W      = 20
) (
  input  wire sys_clk,
  input  wire reset,
  input  wire start,
  output reg  done
);
  reg [W-1:0] cnt_q;
  reg         run_q;

  // ----------------------------------------------------------------------
  // one-shot down counter, done pulses CYCLES edges after start
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1};
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == {W{1'b0}}) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // pfc_timer

// *** design/pfc_top.v ***
`timescale 1ns/1ps
`include "pfc_regs.vh"

module pfc_top #(
  parameter OP_CYCLES = `PFC_OP_CYCLES,
  parameter CNT_W     = 20
) (
  input  wire        sys_clk,
  input  wire        reset,
  // apb slave
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // processor core
  output wire        core_skip,
  output wire        core_stall,
  // flash array
  output wire [14:0] flash_addr,
  output wire [10:0] flash_row_addr,
  output wire        flash_cfg_space,
  output wire        flash_rd,
  input  wire [13:0] flash_rdata,
  output wire [13:0] flash_wdata,
  output reg         flash_erase,
  output reg         flash_program,
  output reg         flash_load
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_RSLOT = 3'd1;
  localparam ST_RACC  = 3'd2;
  localparam ST_WNOP1 = 3'd3;
  localparam ST_WNOP2 = 3'd4;
  localparam ST_STALL = 3'd5;

  reg [7:0] addr_lo_q;
  reg [6:0] addr_hi_q;
  reg [7:0] word_lo_q;
  reg [5:0] word_hi_q;
  reg       rd_q;
  reg       wr_q;
  reg       modify_enable_q;
  reg       modify_error_flag_q;
  reg       load_only_q;
  reg       erase_sel_q;
  reg       config_space_select_q;
  reg       reset_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg       start_rd;
  reg       start_wr;
  reg       hit_alo;
  reg       hit_ahi;
  reg       hit_wlo;
  reg       hit_whi;
  reg       hit_ctl;
  reg       hit_key;
  reg       mapped;
  reg [31:0] rdata_d;
  wire      wr_acc;
  wire      armed;
  wire      op_done;
  wire      latch_only;
  wire      ctl_wr;
  wire      go_wr;
  wire      wr_busy;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_acc  = psel & penable & pwrite;

  always @* begin
    hit_alo = 1'b0;
    hit_ahi = 1'b0;
    hit_wlo = 1'b0;
    hit_whi = 1'b0;
    hit_ctl = 1'b0;
    hit_key = 1'b0;
    if (paddr == `PFC_ADDR_LOW_OFS) begin
      hit_alo = 1'b1;
    end else if (paddr == `PFC_ADDR_HIGH_OFS) begin
      hit_ahi = 1'b1;
    end else if (paddr == `PFC_WORD_LOW_OFS) begin
      hit_wlo = 1'b1;
    end else if (paddr == `PFC_WORD_HIGH_OFS) begin
      hit_whi = 1'b1;
    end else if (paddr == `PFC_CONTROL_OFS) begin
      hit_ctl = 1'b1;
    end else if (paddr == `PFC_KEY_OFS) begin
      hit_key = 1'b1;
    end
    mapped = hit_alo | hit_ahi | hit_wlo | hit_whi | hit_ctl | hit_key;
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    if (hit_alo) begin
      rdata_d[7:0] = addr_lo_q;
    end else if (hit_ahi) begin
      rdata_d[6:0] = addr_hi_q;
    end else if (hit_wlo) begin
      rdata_d[7:0] = word_lo_q;
    end else if (hit_whi) begin
      rdata_d[5:0] = word_hi_q;
    end else if (hit_ctl) begin
      rdata_d[`PFC_CTL_RD]    = rd_q;
      rdata_d[`PFC_CTL_WR]    = wr_q;
      rdata_d[`PFC_CTL_MODIFY_ENABLE]       = modify_enable_q;
      rdata_d[`PFC_CTL_MODIFY_ERROR_FLAG]   = modify_error_flag_q;
      rdata_d[`PFC_CTL_LOAD_ONLY]           = load_only_q;
      rdata_d[`PFC_CTL_ERASE_SEL]           = erase_sel_q;
      rdata_d[`PFC_CTL_CONFIG_SPACE_SELECT] = config_space_select_q;
    end
    // key reads fall through to zero
  end

  // read data is loaded during setup so it stands for the access phase
  always @(posedge sys_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // start conditions
  // ----------------------------------------------------------------------
  assign ctl_wr = wr_acc & hit_ctl;
  assign go_wr  = ctl_wr & pwdata[`PFC_CTL_WR];

  always @* begin
    start_rd = ctl_wr && pwdata[`PFC_CTL_RD] && (state_q == ST_IDLE);
    // write bit only takes with the sequence armed and enable set
    start_wr = go_wr && armed && modify_enable_q
               && (state_q == ST_IDLE) && !start_rd;
  end

  pfc_unlock u_unlock (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .key_wr   (wr_acc & hit_key),
    .key_data (pwdata[7:0]),
    .other_wr (wr_acc & ~hit_key & ~go_wr),
    .go_wr    (go_wr),
    .armed    (armed)
  );

  // ----------------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------------
  assign latch_only = load_only_q & ~erase_sel_q;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_rd) state_d = ST_RSLOT;
        else if (start_wr) state_d = ST_WNOP1;
      end
      // first instruction after the read set runs normally
      ST_RSLOT: state_d = ST_RACC;
      ST_RACC:  state_d = ST_IDLE;
      ST_WNOP1: state_d = ST_WNOP2;
      ST_WNOP2: state_d = latch_only ? ST_IDLE : ST_STALL;
      ST_STALL: begin
        if (op_done) state_d = ST_IDLE;
      end
      default:  state_d = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // only the core is held; this clock and the peripherals keep running
  assign core_stall = (state_q == ST_STALL);
  assign core_skip  = (state_q == ST_RACC)
                      | (state_q == ST_WNOP1)
                      | (state_q == ST_WNOP2);

  pfc_timer #(
    .CYCLES (OP_CYCLES),
    .W      (CNT_W)
  ) u_timer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .start   ((state_q == ST_WNOP2) & ~latch_only),
    .done    (op_done)
  );

  // ----------------------------------------------------------------------
  // flash array strobes
  // ----------------------------------------------------------------------
  assign flash_addr      = {addr_hi_q, addr_lo_q};
  assign flash_row_addr  = flash_addr[14:4];
  assign flash_cfg_space = config_space_select_q;
  assign flash_wdata     = {word_hi_q, word_lo_q};
  assign flash_rd        = (state_q == ST_RACC);

  always @(posedge sys_clk) begin
    if (reset) begin
      flash_erase   <= 1'b0;
      flash_program <= 1'b0;
      flash_load    <= 1'b0;
    end else begin
      flash_erase   <= (state_q == ST_WNOP2) & erase_sel_q;
      flash_program <= (state_q == ST_WNOP2) & ~erase_sel_q & ~load_only_q;
      flash_load    <= (state_q == ST_WNOP2) & latch_only;
    end
  end

  // ----------------------------------------------------------------------
  // reset history
  // ----------------------------------------------------------------------
  // a write is in flight from the cycle after the go write through its two no-ops and, for erase or program, until its stall ends
  assign wr_busy = (state_q == ST_WNOP1) | (state_q == ST_WNOP2)
                   | (state_q == ST_STALL);

  // no reset here: it remembers whether the previous edge was in reset
  always @(posedge sys_clk) begin
    reset_q <= reset;
  end

  // ----------------------------------------------------------------------
  // address and word registers
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      addr_lo_q <= `PFC_BYTE_RST;
      addr_hi_q <= 7'h00;
    end else begin
      if (wr_acc && hit_alo) addr_lo_q <= pwdata[7:0];
      if (wr_acc && hit_ahi) addr_hi_q <= pwdata[6:0];
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      word_lo_q <= `PFC_BYTE_RST;
      word_hi_q <= 6'h00;
    end else if (state_q == ST_RACC) begin
      // array capture wins; the core is skipped in that cycle anyway
      word_lo_q <= flash_rdata[7:0];
      word_hi_q <= flash_rdata[13:8];
    end else begin
      if (wr_acc && hit_wlo) word_lo_q <= pwdata[7:0];
      if (wr_acc && hit_whi) word_hi_q <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      modify_enable_q       <= 1'b0;
      load_only_q           <= 1'b0;
      erase_sel_q           <= 1'b0;
      config_space_select_q <= 1'b0;
    end else if (ctl_wr) begin
      modify_enable_q       <= pwdata[`PFC_CTL_MODIFY_ENABLE];
      load_only_q           <= pwdata[`PFC_CTL_LOAD_ONLY];
      erase_sel_q           <= pwdata[`PFC_CTL_ERASE_SEL];
      config_space_select_q <= pwdata[`PFC_CTL_CONFIG_SPACE_SELECT];
    end
  end

  // only the first edge of a reset pulse can see the cut write; the
  // later edges of the same pulse must keep it, or a long reset loses it
  always @(posedge sys_clk) begin
    if (reset) begin
      if (reset_q && modify_error_flag_q) begin
        modify_error_flag_q <= 1'b1;
      end else begin
        modify_error_flag_q <= wr_busy;
      end
    end else if (ctl_wr && !pwdata[`PFC_CTL_MODIFY_ERROR_FLAG]) begin
      modify_error_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read and write bits
  // ----------------------------------------------------------------------
  // software can only set; hardware clears on completion
  always @(posedge sys_clk) begin
    if (reset) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      if (start_rd) begin
        rd_q <= 1'b1;
      end else if (state_q == ST_RACC) begin
        rd_q <= 1'b0;
      end
      if (start_wr) begin
        wr_q <= 1'b1;
      end else if ((state_q == ST_WNOP2 && latch_only)
                   || (state_q == ST_STALL && op_done)) begin
        wr_q <= 1'b0;
      end
    end
  end
endmodule // pfc_top

// *** design/pfc_unlock.v ***
`timescale 1ns/1ps
`include "pfc_regs.vh"

module pfc_unlock (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       key_wr,
  input  wire [7:0] key_data,
  input  wire       other_wr,
  input  wire       go_wr,
  output wire       armed
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_GOT1  = 2'd1;
  localparam ST_ARMED = 2'd2;

  reg [1:0] state_q;
  reg [1:0] state_d;

  assign armed = (state_q == ST_ARMED);

  // ----------------------------------------------------------------------
  // key sequence tracker
  // ----------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    if (go_wr || other_wr) begin
      state_d = ST_IDLE;
    end else if (key_wr) begin
      case (state_q)
        ST_IDLE: begin
          if (key_data == `PFC_KEY_FIRST) state_d = ST_GOT1;
        end
        ST_GOT1: begin
          if (key_data == `PFC_KEY_SECOND) state_d = ST_ARMED;
          else if (key_data != `PFC_KEY_FIRST) state_d = ST_IDLE;
        end
        default: begin
          // a key write while armed breaks the sequence
          state_d = (key_data == `PFC_KEY_FIRST) ? ST_GOT1 : ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
endmodule // pfc_unlock

// *** dv/pfc_flash_model.sv ***
`timescale 1ns/1ps
// ---------------------------------
// array read port model
// ---------------------------------
module pfc_flash_model (
  input  wire        sys_clk,
  input  wire        flash_rd,
  input  wire [14:0] flash_addr,
  output wire [13:0] flash_rdata
);
  logic tog_q = 1'b0;
  always @(posedge sys_clk) tog_q <= ~tog_q;
  // idle lines churn so a late sample never looks valid
  assign flash_rdata = flash_rd ? (flash_addr[13:0] ^ 14'h1555)
                                : {14{tog_q}};
endmodule // pfc_flash_model

// *** dv/pfc_top_props.sv ***
`timescale 1ns/1ps
`include "pfc_regs.vh"
module pfc_top_props #(
  parameter OP_CYCLES = 400000,
  parameter CNT_W     = 20
) (
  input wire        sys_clk,
  input wire        reset,
  input wire [11:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        core_skip,
  input wire        core_stall,
  input wire [14:0] flash_addr,
  input wire [10:0] flash_row_addr,
  input wire        flash_rd,
  input wire        flash_erase,
  input wire        flash_program,
  input wire        flash_load
);
  logic [31:0] cnt_q;
  always @(posedge sys_clk)
    if (reset) cnt_q <= 32'h0;
    else cnt_q <= core_stall ? cnt_q + 32'h1 : 32'h0;

  a_rd_skip: assert property (
    @(posedge sys_clk) disable iff (reset) flash_rd |-> core_skip)
    else $error("read slot not skipped");
  a_rd_timing: assert property (
    @(posedge sys_clk) disable iff (reset)
    psel && penable && pwrite && paddr == `PFC_CONTROL_OFS && pwdata[0]
    && !core_skip && !core_stall && !flash_rd |=> !flash_rd ##1 flash_rd)
    else $error("read access not in second cycle");
  a_key_zero: assert property (
    @(posedge sys_clk) disable iff (reset) psel && penable && !pwrite
    && paddr == `PFC_KEY_OFS |-> prdata == 32'h0)
    else $error("key read not zero");
  a_op_stall: assert property (
    @(posedge sys_clk) disable iff (reset)
    flash_erase || flash_program |-> core_stall)
    else $error("erase or program without stall");
  a_load_nostall: assert property (
    @(posedge sys_clk) disable iff (reset) flash_load |-> !core_stall)
    else $error("latch load stalled core");
  a_op_skips: assert property (
    @(posedge sys_clk) disable iff (reset)
    flash_erase || flash_program || flash_load
    |-> $past(core_skip) && $past(core_skip, 2))
    else $error("operation without two forced no-ops");
  a_stall_len: assert property (
    @(posedge sys_clk) disable iff (reset)
    $fell(core_stall) |-> cnt_q == OP_CYCLES + 1)
    else $error("stall length wrong");
  a_row_sel: assert property (
    @(posedge sys_clk) disable iff (reset)
    flash_erase |-> flash_row_addr == $past(flash_row_addr, 3))
    else $error("erased row differs from row at go write");
  a_stall_bus: assert property (
    @(posedge sys_clk) disable iff (reset)
    core_stall && psel && !penable && !pwrite
    && paddr == `PFC_ADDR_LOW_OFS |=> prdata[7:0] == $past(flash_addr[7:0]))
    else $error("register read stalled with the core");
endmodule // pfc_top_props

bind pfc_top pfc_top_props #(.OP_CYCLES(OP_CYCLES), .CNT_W(CNT_W)) u_props (
  .sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .core_skip(core_skip), .core_stall(core_stall),
  .flash_addr(flash_addr), .flash_row_addr(flash_row_addr),
  .flash_rd(flash_rd), .flash_erase(flash_erase),
  .flash_program(flash_program), .flash_load(flash_load));

// *** dv/tb_program_flash_read_erase_unlock.sv ***
`timescale 1ns/1ps
`include "pfc_regs.vh"
module tb_program_flash_read_erase_unlock;
  logic        sys_clk, reset, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, core_skip, core_stall, flash_rd;
  logic        flash_erase, flash_program, flash_load;
  logic [14:0] flash_addr;
  logic [10:0] flash_row_addr;
  logic [13:0] flash_rdata, flash_wdata;
  logic        pslverr, flash_cfg_space, slv;
  logic [10:0] er_row;
  int          fails, samples_checked, n_er, n_pg, n_ld;
  localparam logic [11:0] CTL = `PFC_CONTROL_OFS;
  localparam logic [11:0] KEY = `PFC_KEY_OFS;
  localparam logic [11:0] ALO = `PFC_ADDR_LOW_OFS;
  logic [11:0] ra [7] = '{ALO, `PFC_ADDR_HIGH_OFS, `PFC_WORD_LOW_OFS,
                          `PFC_WORD_HIGH_OFS, KEY, 12'h018, CTL};
  logic [7:0]  rw [7] = '{8'hff, 8'hff, 8'ha5, 8'hff, 8'h55, 8'h5a, 8'h04};
  logic [31:0] re [7] = '{32'hff, 32'h7f, 32'ha5, 32'h3f, 32'h0, 32'h0,
                          32'h04};

  pfc_top #(.OP_CYCLES(20)) uut (
    .sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_skip(core_skip),
    .core_stall(core_stall), .flash_addr(flash_addr),
    .flash_row_addr(flash_row_addr), .flash_cfg_space(flash_cfg_space),
    .flash_rd(flash_rd), .flash_rdata(flash_rdata),
    .flash_wdata(flash_wdata),
    .flash_erase(flash_erase), .flash_program(flash_program),
    .flash_load(flash_load));
  pfc_flash_model u_flash (.sys_clk(sys_clk), .flash_rd(flash_rd),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (flash_erase === 1'b1) begin
      n_er++;
      er_row <= flash_row_addr;
    end
    if (flash_program === 1'b1) n_pg++;
    if (flash_load === 1'b1) n_ld++;
  end

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // keys then go; returns two cycles into the stall window
  task automatic unlock(input logic [7:0] c, input logic stray);
    apb(1'b1, CTL, {24'h0, c});
    apb(1'b1, KEY, 32'h55);
    if (stray) apb(1'b1, ALO, 32'h30);
    apb(1'b1, KEY, 32'haa);
    apb(1'b1, CTL, {24'h0, c | 8'h02});
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 40 && core_stall !== 1'b0; i++) @(posedge sys_clk);
    @(posedge sys_clk);
  endtask
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #20000;
    fails++;
    print_verdict();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, CTL, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ra[i], {24'h0, rw[i]});
      apb(1'b0, ra[i], 32'h0);
      chk(rd, re[i]);
    end
    chk(flash_wdata, 32'h3fa5);
    apb(1'b0, 12'h018, 32'h0);
    chk(slv, 32'h1);
    apb(1'b1, CTL, 32'h40);
    apb(1'b0, CTL, 32'h0);
    chk(rd, 32'h40);
    chk(flash_cfg_space, 32'h1);
    apb(1'b1, ALO, 32'h23);
    apb(1'b1, `PFC_ADDR_HIGH_OFS, 32'h01);
    apb(1'b1, CTL, 32'h00);
    apb(1'b1, CTL, 32'h01);
    repeat (3) @(posedge sys_clk);
    chk(flash_cfg_space, 32'h0);
    apb(1'b0, `PFC_WORD_LOW_OFS, 32'h0);
    chk(rd, 32'h76);
    apb(1'b0, `PFC_WORD_HIGH_OFS, 32'h0);
    chk(rd, 32'h14);
    apb(1'b0, CTL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, ALO, 32'h99);
    apb(1'b0, `PFC_WORD_LOW_OFS, 32'h0);
    chk(rd, 32'h76);
    unlock(8'h20, 1'b0);
    wait_idle();
    chk(n_er, 0);
    unlock(8'h24, 1'b1);
    wait_idle();
    chk(n_er, 0);
    unlock(8'h24, 1'b0);
    chk(core_stall, 1);
    apb(1'b0, ALO, 32'h0);
    chk(rd, 32'h30);
    wait_idle();
    chk(n_er, 1);
    chk(er_row, 32'h013);
    apb(1'b0, CTL, 32'h0);
    chk(rd, 32'h24);
    unlock(8'h14, 1'b0);
    chk(core_stall, 0);
    chk(n_ld, 1);
    unlock(8'h04, 1'b0);
    wait_idle();
    chk(n_pg, 1);
    unlock(8'h24, 1'b0);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, CTL, 32'h0);
    chk(rd, 32'h08);
    print_verdict();
  end
endmodule // tb_program_flash_read_erase_unlock
